// ==== core/spir_regs.v ====
`include "spir_defs.vh"
`default_nettype none
module spir_regs (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // special-function bus
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  // status inputs
  input wire dropout_in,
  input wire vdd_above_in,
  input wire wake_in,
  // interrupt sources
  input wire port_match_src,
  input wire dropout_src,
  input wire lin_src,
  input wire cmp_rise_src,
  input wire cmp_fall_src,
  input wire counter_array_src,
  input wire conversion_done_flag,
  input wire window_compare_flag,
  // controls
  output reg regulator_disable,
  output reg regulator_output_select,
  output reg stop_mode,
  output reg idle_mode,
  output reg supply_monitor_en,
  output reg supply_threshold_select,
  output reg level_monitor_en,
  output reg [7:0] irq_req
);
  reg [7:0] eie_r;
  reg rsv6_r;
  reg [3:0] vdm_rsv_r;
  wire [7:0] req_nxt;
  wire wr_pwr = sfr_wr && (sfr_addr == `SPIR_ADDR_PWR);
  wire wr_reg = sfr_wr && (sfr_addr == `SPIR_ADDR_REG);
  wire wr_eie = sfr_wr && (sfr_addr == `SPIR_ADDR_EIE);
  wire wr_vdm = sfr_wr && (sfr_addr == `SPIR_ADDR_VDM);
  wire [7:0] src_vec = {port_match_src, dropout_src, lin_src, cmp_rise_src,
    cmp_fall_src, counter_array_src, conversion_done_flag, window_compare_flag};

  // enable mask applied to each source
  spir_irq_gate u_gate (
    .mask(eie_r),
    .src(src_vec),
    .req(req_nxt)
  );

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eie_r <= `SPIR_RST_EIE;
      rsv6_r <= 1'b1;
      vdm_rsv_r <= 4'h0;
      regulator_disable <= 1'b0;
      regulator_output_select <= 1'b1;
      stop_mode <= 1'b0;
      idle_mode <= 1'b0;
      supply_monitor_en <= 1'b1;
      supply_threshold_select <= 1'b0;
      level_monitor_en <= 1'b1;
      irq_req <= 8'h00;
      sfr_rdata <= 8'h00;
    end else begin
      if (wr_reg) begin
        regulator_disable <= sfr_wdata[`SPIR_REG_DIS];
        rsv6_r <= sfr_wdata[`SPIR_REG_RSV6];
        regulator_output_select <= sfr_wdata[`SPIR_REG_OSEL];
      end
      if (wr_pwr && sfr_wdata[`SPIR_PWR_STOP]) begin
        stop_mode <= 1'b1;
      end else if (wake_in) begin
        stop_mode <= 1'b0;
      end
      if (wr_pwr && sfr_wdata[`SPIR_PWR_IDLE]) begin
        idle_mode <= 1'b1;
      end else if (wake_in) begin
        idle_mode <= 1'b0;
      end
      if (wr_eie) begin
        eie_r <= sfr_wdata;
      end
      if (wr_vdm) begin
        supply_monitor_en <= sfr_wdata[`SPIR_VDM_EN];
        supply_threshold_select <= sfr_wdata[`SPIR_VDM_LVL];
        level_monitor_en <= sfr_wdata[`SPIR_VDM_LEN];
        vdm_rsv_r <= 4'h0;
      end
      irq_req <= req_nxt;
      if (sfr_rd) begin
        case (sfr_addr)
          `SPIR_ADDR_PWR: sfr_rdata <= 8'h00;
          `SPIR_ADDR_REG: sfr_rdata <= {regulator_disable, rsv6_r, 1'b0,
            regulator_output_select, 3'h0, dropout_in};
          `SPIR_ADDR_EIE: sfr_rdata <= eie_r;
          `SPIR_ADDR_VDM: sfr_rdata <= {supply_monitor_en, vdd_above_in,
            supply_threshold_select, level_monitor_en, vdm_rsv_r};
          default: sfr_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== common/spir_defs.vh ====
`ifndef SPIR_DEFS_VH
`define SPIR_DEFS_VH
// register addresses in the special-function space
`define SPIR_ADDR_PWR 8'h87
`define SPIR_ADDR_REG 8'hc9
`define SPIR_ADDR_EIE 8'he6
`define SPIR_ADDR_VDM 8'hff
// reset values
`define SPIR_RST_PWR 8'h00
`define SPIR_RST_REG 8'h50
`define SPIR_RST_EIE 8'h00
`define SPIR_RST_VDM 8'h90
// regulator control fields
`define SPIR_REG_DIS 7
`define SPIR_REG_RSV6 6
`define SPIR_REG_OSEL 4
`define SPIR_REG_DROP 0
// power control fields
`define SPIR_PWR_STOP 1
`define SPIR_PWR_IDLE 0
// interrupt enable fields
`define SPIR_EIE_MAT 7
`define SPIR_EIE_REG 6
`define SPIR_EIE_LIN 5
`define SPIR_EIE_CPR 4
`define SPIR_EIE_CPF 3
`define SPIR_EIE_PCA 2
`define SPIR_EIE_ADC 1
`define SPIR_EIE_WIN 0
// supply monitor fields
`define SPIR_VDM_EN 7
`define SPIR_VDM_STAT 6
`define SPIR_VDM_LVL 5
`define SPIR_VDM_LEN 4
`endif

// ==== core/spir_irq_gate.v ====
`default_nettype none
module spir_irq_gate (
  // mask and sources
  input wire [7:0] mask,
  input wire [7:0] src,
  // gated requests
  output wire [7:0] req
);
  assign req = mask & src;
endmodule
`default_nettype wire

// ==== sim/spir_regs_monitor.sv ====
`default_nettype none
module spir_regs_monitor (
  input wire core_clk, arst_n, sfr_wr, sfr_rd, dropout_in, wake_in, stop_mode, idle_mode,
  input wire regulator_disable, regulator_output_select, supply_threshold_select,
  input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] d = sfr_wdata;
  wire wp = sfr_wr && sfr_addr == 8'h87, wc = sfr_wr && sfr_addr == 8'hc9;
  wire we = sfr_wr && sfr_addr == 8'he6, wf = sfr_wr && sfr_addr == 8'hff;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_dis_wr: assert property (wc |=> regulator_disable == $past(d[7])) else $error("d");
  a_out_sel: assert property (wc |=> regulator_output_select == $past(d[4]))
    else $error("o");
  a_stop_set: assert property (wp && d[1] && !wake_in |=> stop_mode) else $error("s");
  a_idle_set: assert property (wp && d[0] && !wake_in |=> idle_mode) else $error("i");
  a_pwr_zero: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_rdata == 8'h00)
    else $error("p");
  a_drop_bit: assert property (sfr_rd && sfr_addr == 8'hc9 |=> sfr_rdata[0] == $past(dropout_in))
    else $error("r");
  a_irq_off: assert property (we && d == 8'h00 ##1 !sfr_wr |=> irq_req == 8'h00)
    else $error("q");
  a_lvl_wr: assert property (wf |=> supply_threshold_select == $past(d[5])) else $error("l");
  c_stop: cover property (stop_mode && idle_mode);
  c_irq: cover property (irq_req == 8'hff);
  c_drop: cover property (sfr_rd && sfr_addr == 8'hc9 && dropout_in);
endmodule
bind spir_regs spir_regs_monitor mon_u (.*);
`default_nettype wire

// ==== sim/spir_regs_tb.sv ====
`default_nettype none
module spir_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, dropout_in = 0, wake_in = 0;
  logic vdd_above_in = 1, regulator_disable, regulator_output_select, stop_mode, idle_mode;
  logic supply_monitor_en, supply_threshold_select, level_monitor_en;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, irq_req, src = 0, m;
  integer bad_count = 0, n_checks = 0, seed = 32'h4092, i;
  always #20 core_clk = ~core_clk;
  spir_regs dut_u (.*, .port_match_src(src[7]), .dropout_src(src[6]), .lin_src(src[5]),
    .cmp_rise_src(src[4]), .cmp_fall_src(src[3]), .counter_array_src(src[2]),
    .conversion_done_flag(src[1]), .window_compare_flag(src[0]));
  function logic [7:0] gate(input logic [7:0] a, b);
    return a & b;
  endfunction
  task chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // one bus access; on a read d is the expected byte
  task acc(input logic w, input logic [7:0] a, d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge core_clk);
    sfr_wr = 0;
    sfr_rd = 0;
    @(negedge core_clk);
    if (!w) chk("rdata", d, sfr_rdata);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    arst_n = 1;
    acc(0, 8'h87, 8'h00);
    acc(0, 8'hc9, 8'h50);
    acc(0, 8'h3a, 8'h00);
    acc(1, 8'hc9, 8'hc0);
    dropout_in = 1;
    acc(0, 8'hc9, 8'hc1);
    acc(1, 8'h87, 8'h03);
    chk("power", 8'h03, {6'h0, stop_mode, idle_mode});
    acc(0, 8'h87, 8'h00);
    acc(1, 8'hff, 8'hb0);
    chk("level", 8'h01, {7'h0, supply_threshold_select});
    chk("vdm", 8'h07, {5'h0, supply_monitor_en, supply_threshold_select, level_monitor_en});
    acc(0, 8'hff, 8'hf0);
    wake_in = 1;
    @(negedge core_clk);
    wake_in = 0;
    chk("wake", 8'h00, {6'h0, stop_mode, idle_mode});
    $display("control test done");
    for (i = 0; i < 40; i++) begin
      m = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      acc(1, 8'he6, m);
      acc(0, 8'he6, m);
      src = 8'($random(seed));
      @(negedge core_clk);
      chk("irq", gate(m, src), irq_req);
    end
    $display("mask test done");
    stop_test;
  end
endmodule
`default_nettype wire
